// >>> verilog/wam_pkg.sv
// Shared constants and types for the wiper adjust and nonvolatile map block
package wam_pkg;
   localparam int WIPER_W  = 10;
   localparam int DATA_W   = 16;
   localparam int FRAME_W  = 24;
   localparam int NV_WORDS = 16;
   // Frame field positions
   localparam int CMD_LSB  = 20;
   localparam int ADDR_LSB = 16;
   // Nonvolatile map
   localparam logic [3:0] NV_WIPER_ONE  = 4'h0;
   localparam logic [3:0] NV_WIPER_TWO  = 4'h1;
   localparam logic [3:0] USER_FIRST    = 4'h2;
   localparam logic [3:0] USER_LAST     = 4'hE;
   localparam logic [3:0] NV_TOLERANCE  = 4'hF;
   localparam logic [15:0] NV_RESET     = 16'h0000;
   // Tolerance word layout
   localparam int TOL_SIGN_BIT = 15;
   localparam int TOL_INT_LSB  = 8;
   // Wiper codes
   localparam logic [9:0] WIPER_RESET = 10'h000;
   localparam logic [9:0] WIPER_ONE   = 10'h001;
   localparam logic [9:0] WIPER_MID   = 10'h200;
   localparam logic [9:0] WIPER_FULL  = 10'h3FF;
   // Serial receiver
   localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
   localparam logic [4:0] BIT_CNT_FULL = 5'h18;
   localparam logic [4:0] BIT_CNT_MAX  = 5'h1F;
   localparam logic [2:0] SYNC_IDLE    = 3'h2;
   localparam logic [23:0] FRAME_RESET = 24'h000000;

   typedef enum logic [3:0] {
      CMD_NOP         = 4'h0,
      CMD_RESTORE     = 4'h1,
      CMD_STORE       = 4'h2,
      CMD_NV_WRITE    = 4'h3,
      CMD_SHR_ONE     = 4'h4,
      CMD_SHR_ALL     = 4'h5,
      CMD_DEC_ONE     = 4'h6,
      CMD_DEC_ALL     = 4'h7,
      CMD_RESTORE_ALL = 4'h8,
      CMD_NV_READ     = 4'h9,
      CMD_WIPER_READ  = 4'hA,
      CMD_WIPER_WRITE = 4'hB,
      CMD_SHL_ONE     = 4'hC,
      CMD_SHL_ALL     = 4'hD,
      CMD_INC_ONE     = 4'hE,
      CMD_INC_ALL     = 4'hF
   } wam_cmd_t;

   typedef enum logic [2:0] {
      STEP_NONE = 3'h0,
      STEP_INC  = 3'h1,
      STEP_DEC  = 3'h2,
      STEP_SHL  = 3'h3,
      STEP_SHR  = 3'h4
   } wam_step_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b01,
      RX_FRAME = 2'b10
   } wam_rx_state_t;
endpackage

// >>> verilog/wam_frame_if.sv
// Frame hand-over between serial receiver and command logic
interface wam_frame_if;
   logic                        frame_full;
   logic                        frame_empty;
   logic [wam_pkg::FRAME_W-1:0] frame_word;
   logic                        sdo;
   logic                        load_en;
   logic [wam_pkg::DATA_W-1:0]  load_data;
   modport rx  (output frame_full, frame_empty, frame_word, sdo, input load_en, load_data);
   modport ctl (input frame_full, frame_empty, frame_word, sdo, output load_en, load_data);
endinterface

// >>> verilog/wam_step.sv
// Saturating step and shift of one wiper code
module wam_step #(
   parameter int W = 10
) (
   // Operation and current code
   input  wire wam_pkg::wam_step_t op,
   input  wire logic [W-1:0]       cur,
   // Next code
   output logic [W-1:0]            nxt
);
   localparam logic [W-1:0] FULL = {W{1'b1}};
   localparam logic [W-1:0] MID  = {1'b1, {(W-1){1'b0}}};
   localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
   localparam logic [W-1:0] ZERO = {W{1'b0}};

   if (W < 2) begin : g_bad_width
      $error("wam_step needs at least two bits");
   end

   always_comb begin
      case (op)
         wam_pkg::STEP_INC: nxt = (cur == FULL) ? cur : cur + ONE;
         wam_pkg::STEP_DEC: nxt = (cur == ZERO) ? cur : cur - ONE;
         wam_pkg::STEP_SHL: begin
            if (cur == ZERO) nxt = ONE;
            else if (cur >= MID) nxt = FULL;
            else nxt = {cur[W-2:0], 1'b0};
         end
         wam_pkg::STEP_SHR: nxt = {1'b0, cur[W-1:1]};
         default:           nxt = cur;
      endcase
   end
endmodule // wam_step

// >>> verilog/wam_serial_rx.sv
// Serial frame receiver sampled on the system clock
module wam_serial_rx (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   sys_rst,
   // Serial pins
   input  wire logic   sclk,
   input  wire logic   cs_n,
   input  wire logic   sdi,
   // Frame hand-over
   wam_frame_if.rx     fr
);
   logic [2:0]                  sync1_q, sync2_q;
   logic [1:0]                  prev_q;
   wam_pkg::wam_rx_state_t      state_q, state_d;
   logic [wam_pkg::FRAME_W-1:0] sr_q, sr_d;
   logic [4:0]                  cnt_q, cnt_d;
   logic                        sdo_q, sdo_d, full_q, full_d, empty_q, empty_d;
   logic                        sclk_rise, sclk_fall, cs_fall, cs_rise;

   // Two-stage synchronisers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_q <= wam_pkg::SYNC_IDLE;
         sync2_q <= wam_pkg::SYNC_IDLE;
         prev_q  <= wam_pkg::SYNC_IDLE[2:1];
      end else begin
         sync1_q <= {sclk, cs_n, sdi};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q[2:1];
      end
   end

   assign sclk_rise = ~prev_q[1] & sync2_q[2];
   assign sclk_fall = prev_q[1] & ~sync2_q[2];
   assign cs_fall   = prev_q[0] & ~sync2_q[1];
   assign cs_rise   = ~prev_q[0] & sync2_q[1];

   always_comb begin
      state_d = state_q;
      sr_d    = sr_q;
      cnt_d   = cnt_q;
      sdo_d   = sdo_q;
      full_d  = 1'b0;
      empty_d = 1'b0;
      case (state_q)
         wam_pkg::RX_IDLE: begin
            if (cs_fall) begin
               state_d = wam_pkg::RX_FRAME;
               cnt_d   = wam_pkg::BIT_CNT_ZERO;
               if (fr.load_en) sr_d[wam_pkg::DATA_W-1:0] = fr.load_data;
               sdo_d   = sr_d[wam_pkg::FRAME_W-1];
            end
         end
         wam_pkg::RX_FRAME: begin
            if (cs_rise) begin
               state_d = wam_pkg::RX_IDLE;
               full_d  = (cnt_q == wam_pkg::BIT_CNT_FULL);
               empty_d = (cnt_q == wam_pkg::BIT_CNT_ZERO);
            end else begin
               if (sclk_rise) begin
                  sr_d  = {sr_q[wam_pkg::FRAME_W-2:0], sync2_q[0]};
                  cnt_d = (cnt_q == wam_pkg::BIT_CNT_MAX) ? cnt_q : cnt_q + 5'h01;
               end
               if (sclk_fall) sdo_d = sr_q[wam_pkg::FRAME_W-1];
            end
         end
         default: state_d = wam_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= wam_pkg::RX_IDLE;
         sr_q    <= wam_pkg::FRAME_RESET;
         cnt_q   <= wam_pkg::BIT_CNT_ZERO;
         sdo_q   <= 1'b0;
         full_q  <= 1'b0;
         empty_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sr_q    <= sr_d;
         cnt_q   <= cnt_d;
         sdo_q   <= sdo_d;
         full_q  <= full_d;
         empty_q <= empty_d;
      end
   end

   assign fr.frame_full  = full_q;
   assign fr.frame_empty = empty_q;
   assign fr.frame_word  = sr_q;
   assign fr.sdo         = sdo_q;
endmodule // wam_serial_rx

// >>> verilog/wam_top.sv
// Command execution, wiper registers and nonvolatile word map
// What this block does
// - Command 14 raises addressed wiper one step
// - Command 15 raises both wipers one step
// - Commands 6 and 7 lower by one
// - Commands 12 and 13 shift left
// - Commands 4 and 5 shift right
// - Left shift of zero loads one
// - Left shift at midscale or above loads full
// - Full scale stays under further left shift
// - Right shift zero fills, zero stays zero
// - Empty chip select strobe repeats last command
// - Words 0 and 1 hold stored wipers
// - Words 2 to 14 are user words
// - Word 15 tolerance is read only
// - Restore at power-on, commands 1, 8, preset
// - Tolerance: sign, seven integer, eight fraction bits
// - Execute only when chip select rises
// - Steps saturate, never wrap
// - Step and shift ignore data bytes
// - Frame: command nibble, address nibble, 16 data
module wam_top #(
   parameter logic       TOL_SIGN = 1'b1,
   parameter logic [6:0] TOL_INT  = 7'h00,
   parameter logic [7:0] TOL_FRAC = 8'h00
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   // Serial link
   input  wire logic                        sclk,
   input  wire logic                        cs_n,
   input  wire logic                        sdi,
   output logic                             sdo,
   // Preset restore pin
   input  wire logic                        preset_restore_pin_n,
   // Wiper positions
   output logic [wam_pkg::WIPER_W-1:0]      wiper_one,
   output logic [wam_pkg::WIPER_W-1:0]      wiper_two
);
   localparam int W  = wam_pkg::WIPER_W;
   localparam int DW = wam_pkg::DATA_W;
   localparam int NV_USED = wam_pkg::NV_WORDS - 1;
   localparam logic [DW-W-1:0] PAD = '0;
   // Tolerance word encoding
   // sign magnitude
   localparam logic [DW-1:0] TOL_WORD = {TOL_SIGN, TOL_INT, TOL_FRAC};

   wam_frame_if fr ();

   wam_serial_rx u_rx (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .sdi     (sdi),
      .fr      (fr)
   );

   logic                        pr_sync1_q, pr_sync2_q, pr_prev_q, pr_fall;
   logic [W-1:0]                w1_q, w1_d, w2_q, w2_d, nxt1, nxt2;
   logic [wam_pkg::FRAME_W-1:0] last_q, last_d, word;
   logic                        por_q, por_d, rb_pend_q, rb_pend_d;
   logic [DW-1:0]               rb_data_q, rb_data_d;
   logic [DW-1:0]               nv_q [0:NV_USED-1];
   logic                        nv_we;
   logic [3:0]                  nv_addr;
   logic [DW-1:0]               nv_din;
   logic                        exec, plain_exec, sel, gang;
   wam_pkg::wam_cmd_t           cmd;
   logic [3:0]                  addr;
   logic [DW-1:0]               data;
   wam_pkg::wam_step_t          step, op1, op2;

   function automatic logic [DW-1:0] nv_read(input logic [3:0] a);
      if (a == wam_pkg::NV_TOLERANCE) nv_read = TOL_WORD;
      else nv_read = nv_q[a];
   endfunction

   // Preset pin synchroniser
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pr_sync1_q <= 1'b1;
         pr_sync2_q <= 1'b1;
         pr_prev_q  <= 1'b1;
      end else begin
         pr_sync1_q <= preset_restore_pin_n;
         pr_sync2_q <= pr_sync1_q;
         pr_prev_q  <= pr_sync2_q;
      end
   end
   assign pr_fall = pr_prev_q & ~pr_sync2_q;

   assign exec       = fr.frame_full | fr.frame_empty;
   assign plain_exec = exec & ~por_q & ~pr_fall;
   assign word = fr.frame_full ? fr.frame_word : last_q;
   assign cmd  = wam_pkg::wam_cmd_t'(word[wam_pkg::FRAME_W-1:wam_pkg::CMD_LSB]);
   assign addr = word[wam_pkg::CMD_LSB-1:wam_pkg::ADDR_LSB];
   assign data = word[DW-1:0];
   assign sel  = addr[0];

   // step units see no data bytes
   wam_step #(.W(W)) u_step_one (
      .op  (op1),
      .cur (w1_q),
      .nxt (nxt1)
   );
   wam_step #(.W(W)) u_step_two (
      .op  (op2),
      .cur (w2_q),
      .nxt (nxt2)
   );

   always_comb begin
      w1_d      = w1_q;
      w2_d      = w2_q;
      last_d    = fr.frame_full ? fr.frame_word : last_q;
      por_d     = 1'b0;
      rb_pend_d = exec ? 1'b0 : rb_pend_q;
      rb_data_d = rb_data_q;
      nv_we     = 1'b0;
      nv_addr   = wam_pkg::NV_WIPER_ONE;
      nv_din    = wam_pkg::NV_RESET;
      step      = wam_pkg::STEP_NONE;
      gang      = 1'b0;
      op1       = wam_pkg::STEP_NONE;
      op2       = wam_pkg::STEP_NONE;
      if (exec) begin
         case (cmd)
            wam_pkg::CMD_RESTORE: begin
               if (sel) w2_d = nv_q[wam_pkg::NV_WIPER_TWO][W-1:0];
               else w1_d = nv_q[wam_pkg::NV_WIPER_ONE][W-1:0];
            end
            // wiper copies at words 0 and 1
            wam_pkg::CMD_STORE: begin
               nv_we   = 1'b1;
               nv_addr = sel ? wam_pkg::NV_WIPER_TWO : wam_pkg::NV_WIPER_ONE;
               nv_din  = {PAD, sel ? w2_q : w1_q};
            end
            wam_pkg::CMD_NV_WRITE: begin
               nv_we   = (addr != wam_pkg::NV_TOLERANCE);
               nv_addr = addr;
               nv_din  = data;
            end
            wam_pkg::CMD_SHR_ONE: step = wam_pkg::STEP_SHR;
            wam_pkg::CMD_SHR_ALL: begin
               step = wam_pkg::STEP_SHR;
               gang = 1'b1;
            end
            wam_pkg::CMD_DEC_ONE: step = wam_pkg::STEP_DEC;
            wam_pkg::CMD_DEC_ALL: begin
               step = wam_pkg::STEP_DEC;
               gang = 1'b1;
            end
            wam_pkg::CMD_RESTORE_ALL: begin
               w1_d = nv_q[wam_pkg::NV_WIPER_ONE][W-1:0];
               w2_d = nv_q[wam_pkg::NV_WIPER_TWO][W-1:0];
            end
            wam_pkg::CMD_NV_READ: begin
               rb_pend_d = 1'b1;
               rb_data_d = nv_read(addr);
            end
            wam_pkg::CMD_WIPER_READ: begin
               rb_pend_d = 1'b1;
               rb_data_d = {PAD, sel ? w2_q : w1_q};
            end
            wam_pkg::CMD_WIPER_WRITE: begin
               if (sel) w2_d = data[W-1:0];
               else w1_d = data[W-1:0];
            end
            wam_pkg::CMD_SHL_ONE: step = wam_pkg::STEP_SHL;
            wam_pkg::CMD_SHL_ALL: begin
               step = wam_pkg::STEP_SHL;
               gang = 1'b1;
            end
            wam_pkg::CMD_INC_ONE: step = wam_pkg::STEP_INC;
            wam_pkg::CMD_INC_ALL: begin
               step = wam_pkg::STEP_INC;
               gang = 1'b1;
            end
            default: ;
         endcase
      end
      if (gang || !sel) op1 = step;
      if (gang || sel) op2 = step;
      if (op1 != wam_pkg::STEP_NONE) w1_d = nxt1;
      if (op2 != wam_pkg::STEP_NONE) w2_d = nxt2;
      if (por_q || pr_fall) begin
         w1_d = nv_q[wam_pkg::NV_WIPER_ONE][W-1:0];
         w2_d = nv_q[wam_pkg::NV_WIPER_TWO][W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         w1_q      <= wam_pkg::WIPER_RESET;
         w2_q      <= wam_pkg::WIPER_RESET;
         last_q    <= wam_pkg::FRAME_RESET;
         por_q     <= 1'b1;
         rb_pend_q <= 1'b0;
         rb_data_q <= wam_pkg::NV_RESET;
      end else begin
         w1_q      <= w1_d;
         w2_q      <= w2_d;
         last_q    <= last_d;
         por_q     <= por_d;
         rb_pend_q <= rb_pend_d;
         rb_data_q <= rb_data_d;
      end
   end

   // Nonvolatile word array
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NV_USED; i++) begin
            nv_q[i] <= wam_pkg::NV_RESET;
         end
      end else if (nv_we) begin
         nv_q[nv_addr] <= nv_din;
      end
   end

   assign fr.load_en   = rb_pend_q;
   assign fr.load_data = rb_data_q;
   assign sdo          = fr.sdo;
   assign wiper_one    = w1_q;
   assign wiper_two    = w2_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_full_cmd(logic [3:0] c);
      plain_exec && fr.frame_full && cmd == wam_pkg::wam_cmd_t'(c);
   endsequence
   sequence s_repeat_inc;
      plain_exec && fr.frame_empty && cmd == wam_pkg::CMD_INC_ONE && !sel;
   endsequence

   inc_one_a: assert property (s_full_cmd(4'hE) ##0 (!sel && w1_q != wam_pkg::WIPER_FULL)
      |=> w1_q == $past(w1_q) + 10'h001 && w2_q == $past(w2_q))
      else $error("single increment wrong");
   inc_all_a: assert property (plain_exec && cmd == wam_pkg::CMD_INC_ALL
      && w1_q != wam_pkg::WIPER_FULL && w2_q != wam_pkg::WIPER_FULL
      |=> w1_q == $past(w1_q) + 10'h001 && w2_q == $past(w2_q) + 10'h001)
      else $error("ganged increment wrong");
   dec_one_a: assert property (plain_exec && cmd == wam_pkg::CMD_DEC_ONE
      && sel && w2_q != wam_pkg::WIPER_RESET
      |=> w2_q == $past(w2_q) - 10'h001 && w1_q == $past(w1_q))
      else $error("single decrement wrong");
   shl_one_a: assert property (plain_exec && cmd == wam_pkg::CMD_SHL_ONE && !sel
      && w1_q != wam_pkg::WIPER_RESET && w1_q < wam_pkg::WIPER_MID
      |=> w1_q == {$past(w1_q[W-2:0]), 1'b0})
      else $error("left shift wrong");
   shr_all_a: assert property (plain_exec && cmd == wam_pkg::CMD_SHR_ALL
      |=> w1_q == {1'b0, $past(w1_q[W-1:1])} && w2_q == {1'b0, $past(w2_q[W-1:1])})
      else $error("right shift wrong");
   shl_zero_a: assert property (plain_exec && cmd == wam_pkg::CMD_SHL_ONE
      && !sel && w1_q == wam_pkg::WIPER_RESET |=> w1_q == wam_pkg::WIPER_ONE)
      else $error("left shift of zero wrong");
   shl_mid_a: assert property (plain_exec && cmd == wam_pkg::CMD_SHL_ALL
      && w1_q >= wam_pkg::WIPER_MID |=> w1_q == wam_pkg::WIPER_FULL)
      else $error("left shift at midscale wrong");
   shl_full_a: assert property (plain_exec && cmd == wam_pkg::CMD_SHL_ALL
      && w2_q == wam_pkg::WIPER_FULL |=> w2_q == wam_pkg::WIPER_FULL)
      else $error("left shift beyond full scale");
   dec_floor_a: assert property (plain_exec && cmd == wam_pkg::CMD_DEC_ALL
      && w1_q == wam_pkg::WIPER_RESET |=> w1_q == wam_pkg::WIPER_RESET)
      else $error("decrement wrapped");
   repeat_a: assert property (s_repeat_inc ##0 w1_q != wam_pkg::WIPER_FULL
      |=> w1_q == $past(w1_q) + 10'h001)
      else $error("empty strobe did not repeat");
   tol_ro_a: assert property (plain_exec && cmd == wam_pkg::CMD_NV_WRITE
      && addr == wam_pkg::NV_TOLERANCE |=> !$past(nv_we))
      else $error("tolerance word written");
   tol_read_a: assert property (plain_exec && cmd == wam_pkg::CMD_NV_READ
      && addr == wam_pkg::NV_TOLERANCE |=> rb_pend_q
      && rb_data_q[wam_pkg::TOL_SIGN_BIT] == TOL_SIGN
      && rb_data_q[wam_pkg::TOL_SIGN_BIT-1:wam_pkg::TOL_INT_LSB] == TOL_INT
      && rb_data_q[wam_pkg::TOL_INT_LSB-1:0] == TOL_FRAC)
      else $error("tolerance readback wrong");
   user_map_a: assert property (plain_exec && cmd == wam_pkg::CMD_NV_WRITE
      && addr >= wam_pkg::USER_FIRST && addr <= wam_pkg::USER_LAST
      |=> nv_q[$past(addr)] == $past(data))
      else $error("user word not stored");
   store_map_a: assert property (plain_exec && cmd == wam_pkg::CMD_STORE && !sel
      |=> nv_q[wam_pkg::NV_WIPER_ONE] == {PAD, $past(w1_q)})
      else $error("wiper copy not stored");
   preset_a: assert property (pr_fall
      |=> w1_q == nv_q[wam_pkg::NV_WIPER_ONE][W-1:0]
      && w2_q == nv_q[wam_pkg::NV_WIPER_TWO][W-1:0])
      else $error("preset restore missing");
   exec_edge_a: assert property ($changed(w1_q) || $changed(w2_q)
      |-> $past(exec || por_q || pr_fall))
      else $error("wiper moved without frame end");
endmodule // wam_top

// >>> verification/wam_host_model.sv
// Serial host model issuing 24-bit command frames
module wam_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle link: clock still, select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic frame(input logic [23:0] w, output logic [23:0] rx);
      cs_n = 1'b0;
      hold(4);
      for (int i = 23; i >= 0; i--) begin
         sdi = w[i];
         hold(4);
         rx[i] = sdo;
         sclk = 1'b1;
         hold(4);
         sclk = 1'b0;
      end
      hold(4);
      cs_n = 1'b1;
      sdi  = ~sdi;
      hold(8);
   endtask

   task automatic strobe();
      cs_n = 1'b0;
      hold(4);
      cs_n = 1'b1;
      hold(8);
   endtask
endmodule // wam_host_model

// >>> verification/wam_top_tb.sv
// Self-checking bench for the wiper adjust and nonvolatile map block
module wam_top_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic                        clk;
   logic                        sys_rst;
   logic                        sclk;
   logic                        cs_n;
   logic                        sdi;
   logic                        sdo;
   logic                        preset_restore_pin_n;
   logic [wam_pkg::WIPER_W-1:0] wiper_one;
   logic [wam_pkg::WIPER_W-1:0] wiper_two;
   logic [23:0]                 rx;
   int                          miscompares;
   int                          n_checks;

   initial clk = 1'b0;
   always #50 clk = ~clk;

   wam_top #(
      .TOL_SIGN (1'b1),
      .TOL_INT  (7'h1C),
      .TOL_FRAC (8'h0F)
   ) u_wam_top (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .sclk                 (sclk),
      .cs_n                 (cs_n),
      .sdi                  (sdi),
      .sdo                  (sdo),
      .preset_restore_pin_n (preset_restore_pin_n),
      .wiper_one            (wiper_one),
      .wiper_two            (wiper_two)
   );

   wam_host_model u_wam_host_model (
      .clk  (clk),
      .sclk (sclk),
      .cs_n (cs_n),
      .sdi  (sdi),
      .sdo  (sdo)
   );

   task automatic chk_w(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t wiper got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_nv(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [23:0] w);
      u_wam_host_model.frame(w, rx);
   endtask

   task automatic nv_is(input logic [3:0] a, input logic [15:0] exp);
      send({4'h9, a, 16'h0000});
      send(24'h000000);
      chk_nv(rx[15:0], exp);
   endtask

   task automatic t_step();
      send(24'hB003FE);
      send(24'hE0ABCD);
      chk_w(wiper_one, 10'h3FF);
      send(24'hE00000);
      chk_w(wiper_one, 10'h3FF);
      send(24'hB10005);
      send(24'hF05A5A);
      chk_w(wiper_one, 10'h3FF);
      chk_w(wiper_two, 10'h006);
      send(24'h610000);
      chk_w(wiper_two, 10'h005);
      chk_w(wiper_one, 10'h3FF);
      send(24'h700000);
      chk_w(wiper_one, 10'h3FE);
      chk_w(wiper_two, 10'h004);
      send(24'hF00000);
      chk_w(wiper_one, 10'h3FF);
      chk_w(wiper_two, 10'h005);
      send(24'hB10000);
      send(24'h61FFFF);
      chk_w(wiper_two, 10'h000);
      send(24'hB00000);
      send(24'h700000);
      chk_w(wiper_one, 10'h000);
      chk_w(wiper_two, 10'h000);
   endtask

   task automatic t_shift();
      logic [9:0] e;
      send(24'hB00000);
      send(24'hB10000);
      e = 10'h000;
      for (int i = 0; i < 12; i++) begin
         send(24'hD00000);
         e = (e == 10'h000) ? 10'h001 : (e >= 10'h200) ? 10'h3FF : e << 1;
         chk_w(wiper_one, e);
         chk_w(wiper_two, e);
      end
      for (int i = 0; i < 11; i++) begin
         send(24'h400000);
         e = e >> 1;
         chk_w(wiper_one, e);
         chk_w(wiper_two, 10'h3FF);
      end
      send(24'h500000);
      chk_w(wiper_one, 10'h000);
      chk_w(wiper_two, 10'h1FF);
      send(24'hC10000);
      chk_w(wiper_two, 10'h3FE);
      chk_w(wiper_one, 10'h000);
      send(24'hC00000);
      chk_w(wiper_one, 10'h001);
      send(24'hC00000);
      chk_w(wiper_one, 10'h002);
      chk_w(wiper_two, 10'h3FE);
   endtask

   task automatic t_repeat();
      send(24'hB00010);
      send(24'hE00000);
      u_wam_host_model.strobe();
      chk_w(wiper_one, 10'h012);
      u_wam_host_model.strobe();
      chk_w(wiper_one, 10'h013);
   endtask

   task automatic t_nvm();
      send(24'h32BEEF);
      send(24'h3E1234);
      send(24'h3FFFFF);
      nv_is(4'h2, 16'hBEEF);
      nv_is(4'hE, 16'h1234);
      nv_is(4'hF, 16'h9C0F);
   endtask

   task automatic t_restore();
      send(24'hB00155);
      send(24'h200000);
      send(24'hB00000);
      send(24'h100000);
      chk_w(wiper_one, 10'h155);
      send(24'h3102AA);
      send(24'h800000);
      chk_w(wiper_two, 10'h2AA);
      nv_is(4'h0, 16'h0155);
      send(24'hB00001);
      send(24'hB10001);
      preset_restore_pin_n = 1'b0;
      repeat (8) @(negedge clk);
      chk_w(wiper_one, 10'h155);
      chk_w(wiper_two, 10'h2AA);
      preset_restore_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      send(24'hA10000);
      send(24'h000000);
      chk_nv(rx[15:0], 16'h02AA);
   endtask

   task automatic finish_test();
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      miscompares = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      preset_restore_pin_n = 1'b1;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      chk_w(wiper_one, 10'h000);
      chk_w(wiper_two, 10'h000);
      t_step();
      t_shift();
      t_repeat();
      t_nvm();
      t_restore();
      finish_test();
   end

   // Watchdog against a hung link
   initial begin
      repeat (40000) @(negedge clk);
      miscompares++;
      finish_test();
   end
endmodule // wam_top_tb
